// ===== hdl/dsg_pkg.sv
// deep-sleep clock gating bank: shared offsets, field positions, reset values
// assumes a 12-bit byte address slice of the system control space
package dsg_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] DSG_RUN_CFG_OFF    = 12'h060;
  localparam logic [11:0] DSG_RUN_GATE_OFF   = 12'h104;
  localparam logic [11:0] DSG_SLEEP_GATE_OFF = 12'h114;
  localparam logic [11:0] DSG_DEEP_GATE_OFF  = 12'h124;
  localparam logic [11:0] DSG_IRQ_STAT_OFF   = 12'h200;
  localparam logic [11:0] DSG_IRQ_EN_OFF     = 12'h204;
  localparam logic [11:0] DSG_IRQ_CLR_OFF    = 12'h208;

  // ---------------------------------------------------------------
  // gating register field positions
  // ---------------------------------------------------------------
  localparam int unsigned DSG_ASYNC0_BIT  = 0;
  localparam int unsigned DSG_ASYNC1_BIT  = 1;
  localparam int unsigned DSG_SYNC0_BIT   = 4;
  localparam int unsigned DSG_CNT0_BIT    = 16;
  localparam int unsigned DSG_CNT1_BIT    = 17;
  localparam int unsigned DSG_CNT2_BIT    = 18;
  localparam int unsigned DSG_CMP0_BIT    = 24;
  localparam int unsigned DSG_AUTO_GATING_BIT = 27;

  // ---------------------------------------------------------------
  // masks and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] DSG_GATE_MASK  = 32'h0107_0013;
  localparam logic [31:0] DSG_GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] DSG_CFG_MASK   = 32'h0800_0000;
  localparam logic [31:0] DSG_CFG_RESET  = 32'h0000_0000;
  localparam logic [6:0]  DSG_IRQ_RESET  = 7'h00;

  localparam int unsigned DSG_NUM_PERIPH = 7;

  // ---------------------------------------------------------------
  // power mode selecting which gating register applies
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DSG_MODE_RUN,
    DSG_MODE_SLEEP,
    DSG_MODE_DEEP
  } dsg_mode_type;

endpackage : dsg_pkg

// ===== hdl/dsg_clk_gate.sv
// glitch-free clock gate for one peripheral clock
// assumes i_en is synchronous to i_clk and changes after a rising edge
`timescale 1ns/1ps
`default_nettype none
module dsg_clk_gate (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // enable and gated clock
  input  wire logic i_en,
  output logic      o_gclk
);

  logic en_low;

  // enable retimed while the clock is low, so the gated pulse is never cut
  always_ff @(negedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_low <= 1'b0;
    end else begin
      en_low <= i_en;
    end
  end

  assign o_gclk = i_clk & en_low;

endmodule : dsg_clk_gate
`default_nettype wire

// ===== hdl/dsg_top.sv
// deep-sleep clock gating bank with run and sleep companions, apb slave
// assumes apb master, power manager and bus decoder share i_ref_clk
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dsg_top #(
  parameter int unsigned NUM_PERIPH = dsg_pkg::DSG_NUM_PERIPH
) (
  // clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  input  wire logic [3:0]            i_pstrb,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // power manager
  input  wire logic                  i_sleep,
  input  wire logic                  i_deep_sleep,
  // peripheral access requests from the system bus decoder
  input  wire logic [NUM_PERIPH-1:0] i_periph_access,
  output logic                       o_bus_fault,
  output logic [NUM_PERIPH-1:0]      o_fault_periph,
  // gated peripheral clocks and enables
  output logic [NUM_PERIPH-1:0]      o_periph_clk,
  output logic [NUM_PERIPH-1:0]      o_periph_clk_en,
  // interrupt
  output logic                       o_irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0]             run_clock_gate_1;
  logic [31:0]             sleep_clock_gate_1;
  logic [31:0]             deep_sleep_clock_gate_1;
  logic [31:0]             run_clock_config;
  logic [NUM_PERIPH-1:0]   irq_status;
  logic [NUM_PERIPH-1:0]   irq_enable;
  logic                    auto_gating_select;
  dsg_pkg::dsg_mode_type   mode;
  dsg_pkg::dsg_mode_type   next_mode;
  logic [31:0]             next_sel_gate;
  logic [NUM_PERIPH-1:0]   next_clk_en;
  logic                    setup_phase;
  logic                    access_phase;
  logic                    wr_access;
  logic                    addr_hit;
  logic [31:0]             next_rdata;
  logic                    slv_err;
  logic [NUM_PERIPH-1:0]   fault_hits;
  logic [NUM_PERIPH-1:0]   irq_clear;
  logic                    wr_run_cfg;
  logic                    wr_run_gate;
  logic                    wr_sleep_gate;
  logic                    wr_deep_gate;
  logic                    wr_irq_en;
  logic                    wr_irq_clr;

  // ---------------------------------------------------------------
  // byte-lane merge of a write into a masked register
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge_write(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] merged;
    merged = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merged[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    // reserved and unimplemented bits always land as zero
    return merged & mask;
  endfunction : merge_write

  // ---------------------------------------------------------------
  // gate register bit to peripheral index
  // ---------------------------------------------------------------
  function automatic logic [NUM_PERIPH-1:0] gate_to_periph(input logic [31:0] g);
    logic [NUM_PERIPH-1:0] p;
    p    = '0;
    p[0] = g[dsg_pkg::DSG_ASYNC0_BIT];
    p[1] = g[dsg_pkg::DSG_ASYNC1_BIT];
    p[2] = g[dsg_pkg::DSG_SYNC0_BIT];
    p[3] = g[dsg_pkg::DSG_CNT0_BIT];
    p[4] = g[dsg_pkg::DSG_CNT1_BIT];
    p[5] = g[dsg_pkg::DSG_CNT2_BIT];
    p[6] = g[dsg_pkg::DSG_CMP0_BIT];
    return p;
  endfunction : gate_to_periph

  // ---------------------------------------------------------------
  // apb phase decode
  // ---------------------------------------------------------------
  assign setup_phase  = i_psel & ~i_penable;
  assign access_phase = i_psel & i_penable;
  assign wr_access    = access_phase & i_pwrite;

  // ---------------------------------------------------------------
  // per-register write selects
  // ---------------------------------------------------------------
  assign wr_run_cfg    = wr_access & (i_paddr == dsg_pkg::DSG_RUN_CFG_OFF);
  assign wr_run_gate   = wr_access & (i_paddr == dsg_pkg::DSG_RUN_GATE_OFF);
  assign wr_sleep_gate = wr_access & (i_paddr == dsg_pkg::DSG_SLEEP_GATE_OFF);
  assign wr_deep_gate  = wr_access & (i_paddr == dsg_pkg::DSG_DEEP_GATE_OFF);
  assign wr_irq_en     = wr_access & (i_paddr == dsg_pkg::DSG_IRQ_EN_OFF);
  assign wr_irq_clr    = wr_access & (i_paddr == dsg_pkg::DSG_IRQ_CLR_OFF);

  always_comb begin
    addr_hit = 1'b1;
    case (i_paddr)
      dsg_pkg::DSG_RUN_CFG_OFF,
      dsg_pkg::DSG_RUN_GATE_OFF,
      dsg_pkg::DSG_SLEEP_GATE_OFF,
      dsg_pkg::DSG_DEEP_GATE_OFF,
      dsg_pkg::DSG_IRQ_STAT_OFF,
      dsg_pkg::DSG_IRQ_EN_OFF,
      dsg_pkg::DSG_IRQ_CLR_OFF: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // gating registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_clock_gate_1 <= dsg_pkg::DSG_GATE_RESET;
    end else if (wr_run_gate) begin
      run_clock_gate_1 <= merge_write(run_clock_gate_1, i_pwdata, i_pstrb,
                                      dsg_pkg::DSG_GATE_MASK);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sleep_clock_gate_1 <= dsg_pkg::DSG_GATE_RESET;
    end else if (wr_sleep_gate) begin
      sleep_clock_gate_1 <= merge_write(sleep_clock_gate_1, i_pwdata, i_pstrb,
                                        dsg_pkg::DSG_GATE_MASK);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      deep_sleep_clock_gate_1 <= dsg_pkg::DSG_GATE_RESET;
    end else if (wr_deep_gate) begin
      deep_sleep_clock_gate_1 <= merge_write(deep_sleep_clock_gate_1, i_pwdata,
                                             i_pstrb, dsg_pkg::DSG_GATE_MASK);
    end
  end

  // only the auto gating select bit is implemented here
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_clock_config <= dsg_pkg::DSG_CFG_RESET;
    end else if (wr_run_cfg) begin
      run_clock_config <= merge_write(run_clock_config, i_pwdata, i_pstrb,
                                      dsg_pkg::DSG_CFG_MASK);
    end
  end

  assign auto_gating_select = run_clock_config[dsg_pkg::DSG_AUTO_GATING_BIT];

  // ---------------------------------------------------------------
  // power mode tracking
  // ---------------------------------------------------------------
  always_comb begin
    next_mode = dsg_pkg::DSG_MODE_RUN;
    if (auto_gating_select && i_deep_sleep) begin
      next_mode = dsg_pkg::DSG_MODE_DEEP;
    end else if (auto_gating_select && i_sleep) begin
      next_mode = dsg_pkg::DSG_MODE_SLEEP;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= dsg_pkg::DSG_MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // ---------------------------------------------------------------
  // effective clock enables
  // ---------------------------------------------------------------
  always_comb begin
    case (mode)
      dsg_pkg::DSG_MODE_RUN: begin
        next_sel_gate = run_clock_gate_1;
      end
      dsg_pkg::DSG_MODE_SLEEP: begin
        next_sel_gate = sleep_clock_gate_1;
      end
      dsg_pkg::DSG_MODE_DEEP: begin
        next_sel_gate = deep_sleep_clock_gate_1;
      end
      default: begin
        next_sel_gate = run_clock_gate_1;
      end
    endcase
    next_clk_en = gate_to_periph(next_sel_gate);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_periph_clk_en <= '0;
    end else begin
      o_periph_clk_en <= next_clk_en;
    end
  end

  // one glitch-free gate per peripheral clock
  for (genvar p = 0; p < NUM_PERIPH; p++) begin : g_gate
    dsg_clk_gate u_gate (
      .i_clk   (i_ref_clk),
      .i_rst_n (i_rst_n),
      .i_en    (o_periph_clk_en[p]),
      .o_gclk  (o_periph_clk[p])
    );
  end

  // ---------------------------------------------------------------
  // bus fault on access to an unclocked peripheral
  // ---------------------------------------------------------------
  // decoder sees the registered enable, as the gated clock does
  assign fault_hits = i_periph_access & ~o_periph_clk_en;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_fault    <= 1'b0;
      o_fault_periph <= '0;
    end else begin
      o_bus_fault    <= |fault_hits;
      o_fault_periph <= fault_hits;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, enable and clear
  // ---------------------------------------------------------------
  assign irq_clear = (wr_irq_clr && i_pstrb[0])
                     ? i_pwdata[NUM_PERIPH-1:0] : '0;

  // a fault in the clearing cycle keeps its bit set
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= dsg_pkg::DSG_IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | fault_hits;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_enable <= dsg_pkg::DSG_IRQ_RESET;
    end else if (wr_irq_en && i_pstrb[0]) begin
      irq_enable <= i_pwdata[NUM_PERIPH-1:0];
    end
  end

  assign o_irq = |(irq_status & irq_enable);

  // ---------------------------------------------------------------
  // read data and error, captured in the setup cycle
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_paddr)
      dsg_pkg::DSG_RUN_CFG_OFF: begin
        next_rdata = run_clock_config;
      end
      dsg_pkg::DSG_RUN_GATE_OFF: begin
        next_rdata = run_clock_gate_1;
      end
      dsg_pkg::DSG_SLEEP_GATE_OFF: begin
        next_rdata = sleep_clock_gate_1;
      end
      dsg_pkg::DSG_DEEP_GATE_OFF: begin
        next_rdata = deep_sleep_clock_gate_1;
      end
      dsg_pkg::DSG_IRQ_STAT_OFF: begin
        next_rdata[NUM_PERIPH-1:0] = irq_status;
      end
      dsg_pkg::DSG_IRQ_EN_OFF: begin
        next_rdata[NUM_PERIPH-1:0] = irq_enable;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : next_rdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slv_err <= 1'b0;
    end else if (setup_phase) begin
      slv_err <= ~addr_hit;
    end
  end

  // zero wait states: every access ends in its first access cycle
  assign o_pready  = access_phase;
  assign o_pslverr = access_phase & slv_err;

endmodule : dsg_top
`default_nettype wire

// ===== sim/dsg_props.sv
// checker for the deep-sleep gating bank: apb answers, faults, enables
// assumes binding to dsg_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dsg_props #(
  parameter int unsigned NUM_PERIPH = 7
) (
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_psel,
  input wire logic                  i_penable,
  input wire logic                  i_pwrite,
  input wire logic [11:0]           i_paddr,
  input wire logic [31:0]           i_pwdata,
  input wire logic [3:0]            i_pstrb,
  input wire logic                  o_pready,
  input wire logic                  o_pslverr,
  input wire logic                  i_sleep,
  input wire logic                  i_deep_sleep,
  input wire logic [NUM_PERIPH-1:0] i_periph_access,
  input wire logic                  o_bus_fault,
  input wire logic [NUM_PERIPH-1:0] o_fault_periph,
  input wire logic [NUM_PERIPH-1:0] o_periph_clk_en
);
  // ---------------------------------------------------------------
  // helpers and properties
  // ---------------------------------------------------------------
  logic [NUM_PERIPH-1:0] gath;
  logic [NUM_PERIPH-1:0] miss;
  logic                  run_wr;
  assign gath = {i_pwdata[24], i_pwdata[18:16], i_pwdata[4], i_pwdata[1:0]};
  assign miss = i_periph_access & ~o_periph_clk_en;
  assign run_wr = i_psel && i_penable && i_pwrite && i_pstrb == 4'hf &&
                  i_paddr == dsg_pkg::DSG_RUN_GATE_OFF && !i_sleep && !i_deep_sleep;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_fault_on_gated: assert property (|miss |=> o_bus_fault && o_fault_periph == $past(miss))
    else $error("no fault for gated access");
  a_no_false_fault: assert property (!(|miss) |=> !o_bus_fault)
    else $error("fault without gated access");
  a_fault_flags_agree: assert property (o_bus_fault == (|o_fault_periph))
    else $error("fault flags disagree");
  a_run_gate_applies: assert property (run_wr ##1 (!i_sleep && !i_deep_sleep)
    |=> o_periph_clk_en == $past(gath, 2)) else $error("enables do not follow gate");
  a_reset_all_off: assert property ($rose(i_rst_n) |-> o_periph_clk_en == '0)
    else $error("enables set after reset");
  a_en_holds_idle: assert property ((!i_psel && $stable(i_sleep) && $stable(i_deep_sleep))[*4]
    |-> $stable(o_periph_clk_en)) else $error("enables moved while idle");
  a_zero_wait_ready: assert property (i_psel && i_penable |-> o_pready)
    else $error("no ready in access");
  a_gate_no_error: assert property (i_psel && i_penable &&
    i_paddr == dsg_pkg::DSG_DEEP_GATE_OFF |-> !o_pslverr) else $error("error on gate reg");
  c_gated_access: cover property (|miss);
  c_run_write: cover property (run_wr);
  c_slave_error: cover property (o_pslverr);
endmodule : dsg_props
bind dsg_top dsg_props #(.NUM_PERIPH(NUM_PERIPH)) u_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep),
  .i_deep_sleep(i_deep_sleep), .i_periph_access(i_periph_access),
  .o_bus_fault(o_bus_fault), .o_fault_periph(o_fault_periph),
  .o_periph_clk_en(o_periph_clk_en)
);
`default_nettype wire

// ===== sim/dsg_periph_model.sv
// gated peripherals: count own clock edges, issue bus accesses on request
// assumes touch() is called right after a rising edge of i_clk
`timescale 1ns/1ps
`default_nettype none
module dsg_periph_model (
  // clocks
  input  wire logic       i_clk,
  input  wire logic [6:0] i_gclk,
  // decoder side
  output logic [6:0]      o_access,
  output logic [6:0][7:0] o_ticks
);
  // ---------------------------------------------------------------
  // edge counters and access pulses
  // ---------------------------------------------------------------
  initial o_access = 7'h00;
  initial o_ticks = '0;
  for (genvar g = 0; g < 7; g++) begin : g_cnt
    always @(posedge i_gclk[g]) o_ticks[g] <= o_ticks[g] + 8'h01;
  end
  task automatic touch(input int p);
    @(posedge i_clk);
    o_access[p] <= 1'b1;
    @(posedge i_clk);
    o_access <= 7'h00;
  endtask : touch
endmodule : dsg_periph_model
`default_nettype wire

// ===== sim/deep_sleep_clock_gating_bank1_bench.sv
// testbench for the deep-sleep gating bank over apb
// assumes dsg_top, dsg_props bound to it and the peripheral model
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_clock_gating_bank1_bench;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, serr, fault, irq, sleep = 1'b0, deep = 1'b0;
  logic [6:0] access, fault_p, pclk, pen;
  logic [6:0][7:0] ticks;
  logic [7:0] t0, t1;
  int err_count = 0, total_checks = 0, cycles = 0;
  int unsigned pos [7] = '{0, 1, 4, 16, 17, 18, 24};
  always #2 clk = ~clk;
  dsg_top #(.NUM_PERIPH(7)) DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sleep(sleep), .i_deep_sleep(deep), .i_periph_access(access),
    .o_bus_fault(fault), .o_fault_periph(fault_p), .o_periph_clk(pclk),
    .o_periph_clk_en(pen), .o_irq(irq));
  dsg_periph_model m (.i_clk(clk), .i_gclk(pclk), .o_access(access), .o_ticks(ticks));
  // ---------------------------------------------------------------
  // checking, bus tasks, closing
  // ---------------------------------------------------------------
  task automatic test_done();
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    n = 0;
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    rdv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 0);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rdv, exp);
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("Error at %0t: run timed out", $time);
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pen, 0);
    rd(dsg_pkg::DSG_DEEP_GATE_OFF, 32'h0);
    rd(dsg_pkg::DSG_RUN_GATE_OFF, 32'h0);
    wr(dsg_pkg::DSG_DEEP_GATE_OFF, 32'hffff_ffff);
    rd(dsg_pkg::DSG_DEEP_GATE_OFF, 32'h0107_0013);
    wr(dsg_pkg::DSG_DEEP_GATE_OFF, 32'h0);
    apb(1'b1, dsg_pkg::DSG_DEEP_GATE_OFF, 32'hffff_ffff, 4'h1);
    rd(dsg_pkg::DSG_DEEP_GATE_OFF, 32'h0000_0013);
    wr(dsg_pkg::DSG_RUN_CFG_OFF, 32'h0800_0000);
    deep <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wr(dsg_pkg::DSG_DEEP_GATE_OFF, 32'h1 << pos[i]);
      rd(dsg_pkg::DSG_DEEP_GATE_OFF, 32'h1 << pos[i]);
      settle();
      chk(pen, 32'h1 << i);
      t0 = ticks[(i + 1) % 7];
      t1 = ticks[i];
      repeat (4) @(posedge clk);
      #1;
      chk({24'h0, ticks[i] - t1}, 32'h4);
      chk({24'h0, ticks[(i + 1) % 7] - t0}, 32'h0);
    end
    @(posedge clk) deep <= 1'b0;
    settle();
    chk(pen, 0);
    wr(dsg_pkg::DSG_RUN_CFG_OFF, 32'h0);
    deep <= 1'b1;
    settle();
    chk(pen, 0);
    wr(dsg_pkg::DSG_SLEEP_GATE_OFF, 32'h10);
    wr(dsg_pkg::DSG_RUN_CFG_OFF, 32'h0800_0000);
    sleep <= 1'b1;
    deep <= 1'b0;
    settle();
    chk(pen, 32'h04);
    @(posedge clk) deep <= 1'b1;
    settle();
    chk(pen, 32'h40);
    @(posedge clk) sleep <= 1'b0;
    deep <= 1'b0;
    wr(dsg_pkg::DSG_IRQ_EN_OFF, 32'h1);
    m.touch(0);
    #1;
    chk({fault, fault_p, irq}, {1'b1, 7'h01, 1'b1});
    rd(dsg_pkg::DSG_IRQ_STAT_OFF, 32'h1);
    wr(dsg_pkg::DSG_IRQ_CLR_OFF, 32'h1);
    #1;
    chk(irq, 0);
    m.touch(1);
    #1;
    chk({fault, fault_p, irq}, {1'b1, 7'h02, 1'b0});
    rd(dsg_pkg::DSG_IRQ_STAT_OFF, 32'h2);
    wr(dsg_pkg::DSG_RUN_GATE_OFF, 32'h2);
    settle();
    m.touch(1);
    #1;
    chk(fault, 0);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({fault, irq, pen}, 9'h000);
    rd(dsg_pkg::DSG_RUN_GATE_OFF, 32'h0);
    rd(dsg_pkg::DSG_IRQ_STAT_OFF, 32'h0);
    apb(1'b0, 12'h300, 32'h0, 4'hf);
    chk({serr, rdv}, {1'b1, 32'h0});
    test_done();
  end
endmodule : deep_sleep_clock_gating_bank1_bench
`default_nettype wire
